/* logic/seebs_top.sv */
// Slave command engine of a two-wire serial EEPROM with page latch and array.
// Assumes a free running sampling clock for the bus pins and a core clock for
// the program timer; SDA is open drain and resolved outside.
`timescale 1ns/1ps
`include "seebs_regs.svh"

module seebs_top
	import seebs_pkg::*;
#(
	parameter int unsigned ADDR_W = `SEEBS_ADDR_W_LARGE,
	parameter logic [6:0] DEV_ID = `SEEBS_DEV_ID_DEFAULT,
	parameter int unsigned PROG_CYCLES = `SEEBS_PROG_CYCLES
)
(
	input wire logic CLK,
	input wire logic RST,
	input wire logic BUS_SAMPLE_CLK,
	input wire logic SCL,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	input wire logic WRITE_PROTECT_INPUT
);

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	localparam int unsigned MEM_BYTES = 1 << ADDR_W;

	seebs_link_t s_r;
	seebs_link_t s_nxt;
	logic lrst_s1_r;
	logic lrst_r;
	logic done_tgl;
	logic busy;
	logic start_seen;
	logic stop_seen;
	logic scl_rise;
	logic scl_fall;
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [7:0] wr_data;

	// The array is the nonvolatile store; reset does not touch it.
	logic [7:0] mem [0:MEM_BYTES-1] = '{default: `SEEBS_ERASED_BYTE};

	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------

	// Index into the array; bits above the capacity are simply dropped.
	function automatic logic [ADDR_W-1:0] mem_index(input logic [`SEEBS_ADDR_BITS-1:0] a);
		mem_index = a[ADDR_W-1:0];
	endfunction : mem_index

	// Counter advance inside one row: the row bits are left alone.
	function automatic logic [`SEEBS_ADDR_BITS-1:0] row_step(
		input logic [`SEEBS_ADDR_BITS-1:0] a);
		logic [`SEEBS_PAGE_BITS-1:0] low;
		low = a[`SEEBS_PAGE_BITS-1:0] + `SEEBS_PAGE_BITS'(1);
		row_step = {a[`SEEBS_ADDR_BITS-1:`SEEBS_PAGE_BITS], low};
	endfunction : row_step

	// ------------------------------------------------------------------------
	// Reset crossing into the link domain
	// ------------------------------------------------------------------------

	// The core reset is resynchronised so the link logic leaves reset cleanly.
	always_ff @(posedge BUS_SAMPLE_CLK)
	begin
		lrst_s1_r <= RST;
		lrst_r <= lrst_s1_r;
	end

	// ------------------------------------------------------------------------
	// Program timer on the core clock
	// ------------------------------------------------------------------------
	seebs_prog_timer #(
		.PROG_CYCLES(PROG_CYCLES)
	) u_timer (
		.clk(CLK),
		.rst(RST),
		.start_tgl(s_r.prog_t),
		.done_tgl(done_tgl)
	);

	// ------------------------------------------------------------------------
	// Bus events seen from the synchronised pins
	// ------------------------------------------------------------------------

	// Only the second synchroniser stage and its delayed copy are compared.
	assign start_seen = s_r.scl_s2 & s_r.scl_p & s_r.sda_p & ~s_r.sda_s2;
	assign stop_seen = s_r.scl_s2 & s_r.scl_p & ~s_r.sda_p & s_r.sda_s2;
	assign scl_rise = s_r.scl_s2 & ~s_r.scl_p;
	assign scl_fall = ~s_r.scl_s2 & s_r.scl_p;

	// Busy covers the latch copy and the whole timed write.
	assign busy = s_r.committing | (s_r.prog_t != s_r.done_s2);

	// ------------------------------------------------------------------------
	// Next state of the link engine
	// ------------------------------------------------------------------------

	// One pass decides the sampling, the protocol step and the latch copy.
	always_comb
	begin
		s_nxt = s_r;
		wr_en = 1'b0;
		wr_addr = '0;
		wr_data = 8'h00;
		s_nxt.scl_s1 = SCL;
		s_nxt.scl_s2 = s_r.scl_s1;
		s_nxt.scl_p = s_r.scl_s2;
		s_nxt.sda_s1 = SDA_I;
		s_nxt.sda_s2 = s_r.sda_s1;
		s_nxt.sda_p = s_r.sda_s2;
		s_nxt.wp_s1 = WRITE_PROTECT_INPUT;
		s_nxt.wp_s2 = s_r.wp_s1;
		s_nxt.done_s1 = done_tgl;
		s_nxt.done_s2 = s_r.done_s1;
		s_nxt.sda_o = 1'b0;
		// The output byte is prefetched every cycle so it is ready at the ack edge.
		s_nxt.rdata = mem[mem_index(s_r.addr)];

		// Protect is watched from the start up to the end of the address.
		if ((s_r.st == SEEBS_DEVSEL) || (s_r.st == SEEBS_ADDR_HI) ||
			(s_r.st == SEEBS_ADDR_LO))
			s_nxt.wp_seen = s_r.wp_seen | s_r.wp_s2;

		if (s_r.committing)
		begin
			// Latched bytes go into their row one per cycle; others stay as they were.
			if (s_r.valid[s_r.cidx])
			begin
				wr_en = 1'b1;
				wr_addr = {s_r.addr[ADDR_W-1:`SEEBS_PAGE_BITS], s_r.cidx};
				wr_data = s_r.latch[s_r.cidx];
			end
			s_nxt.cidx = s_r.cidx + `SEEBS_PAGE_BITS'(1);
			if (s_r.cidx == `SEEBS_PAGE_BITS'(`SEEBS_PAGE_BYTES - 1))
			begin
				s_nxt.committing = 1'b0;
				s_nxt.valid = '0;
			end
		end
		else if (busy)
		begin
			// Starts, stops and clocks pass unseen while the write runs.
			// A polling select therefore finds no acknowledge.
			s_nxt.st = SEEBS_IDLE;
			s_nxt.oe = 1'b0;
		end
		else if (start_seen)
		begin
			// A start, repeated or not, begins a new select byte.
			s_nxt.st = SEEBS_DEVSEL;
			s_nxt.bit_cnt = `SEEBS_START_BIT;
			s_nxt.oe = 1'b0;
			s_nxt.slot10 = 1'b0;
			s_nxt.wp_seen = s_r.wp_s2;
			s_nxt.valid = '0;
		end
		else if (stop_seen)
		begin
			// Programming needs a stop in the slot right after a data ack.
			if (s_r.slot10 && (s_r.st == SEEBS_WDATA) && (s_r.valid != '0))
			begin
				s_nxt.committing = 1'b1;
				s_nxt.cidx = '0;
				s_nxt.prog_t = ~s_r.prog_t;
			end
			s_nxt.st = SEEBS_IDLE;
			s_nxt.oe = 1'b0;
			s_nxt.slot10 = 1'b0;
		end
		else if ((s_r.st != SEEBS_IDLE) && scl_rise)
		begin
			if (s_r.bit_cnt <= `SEEBS_LAST_DATA_BIT)
			begin
				// Incoming bits shift in MSB first on the rising edge.
				if (s_r.st != SEEBS_RDATA)
					s_nxt.sh = {s_r.sh[6:0], s_r.sda_s2};
			end
			else if (s_r.st == SEEBS_RDATA)
				s_nxt.mack = ~s_r.sda_s2;
		end
		else if ((s_r.st != SEEBS_IDLE) && scl_fall)
		begin
			// The tenth slot lasts until the clock after the ack falls again.
			s_nxt.slot10 = 1'b0;
			// The fall that closes a start ends no bit, so it must not be counted.
			if (s_r.bit_cnt == `SEEBS_START_BIT)
				s_nxt.bit_cnt = 4'h0;
			else if (s_r.bit_cnt < `SEEBS_LAST_DATA_BIT)
			begin
				s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
				if (s_r.st == SEEBS_RDATA)
				begin
					// Open drain: drive low for a zero, release for a one.
					s_nxt.sh = {s_r.sh[6:0], 1'b0};
					s_nxt.oe = ~s_r.sh[6];
				end
			end
			else if (s_r.bit_cnt == `SEEBS_LAST_DATA_BIT)
			begin
				s_nxt.bit_cnt = `SEEBS_ACK_BIT;
				s_nxt.oe = 1'b0;
				case (s_r.st)
					SEEBS_DEVSEL:
					begin
						if (s_r.sh[7:1] == DEV_ID)
						begin
							s_nxt.oe = 1'b1;
							s_nxt.rw = s_r.sh[0]; // One reads, zero writes.
						end
						else
							s_nxt.st = SEEBS_IDLE;
					end
					SEEBS_ADDR_HI:
					begin
						s_nxt.oe = 1'b1;
						s_nxt.addr[15:8] = s_r.sh;
					end
					SEEBS_ADDR_LO:
					begin
						s_nxt.oe = 1'b1;
						s_nxt.addr[7:0] = s_r.sh; // The counter is loaded with no data.
					end
					SEEBS_WDATA:
					begin
						// Protected data bytes get no ack and leave the latch alone.
						if (!s_r.wp_seen)
						begin
							s_nxt.oe = 1'b1;
							s_nxt.latch[s_r.addr[`SEEBS_PAGE_BITS-1:0]] = s_r.sh;
							s_nxt.valid[s_r.addr[`SEEBS_PAGE_BITS-1:0]] = 1'b1;
							s_nxt.addr = row_step(s_r.addr); // Excess bytes wrap.
						end
					end
					SEEBS_RDATA:
					begin
						// Released so the master can answer in the ninth slot.
						s_nxt.mack = 1'b0;
					end
					default:
						s_nxt.st = SEEBS_IDLE;
				endcase
			end
			else
			begin
				// End of the ninth bit: release the line and take the next step.
				s_nxt.bit_cnt = 4'h0;
				s_nxt.oe = 1'b0;
				case (s_r.st)
					SEEBS_DEVSEL:
					begin
						if (s_r.rw)
						begin
							// Reads take the current counter, whatever protect shows.
							s_nxt.st = SEEBS_RDATA;
							s_nxt.sh = s_r.rdata;
							s_nxt.oe = ~s_r.rdata[7];
							s_nxt.addr = s_r.addr + 16'h1;
						end
						else
							s_nxt.st = SEEBS_ADDR_HI;
					end
					SEEBS_ADDR_HI:
						s_nxt.st = SEEBS_ADDR_LO;
					SEEBS_ADDR_LO:
						s_nxt.st = SEEBS_WDATA;
					SEEBS_WDATA:
					begin
						// Only an acknowledged byte opens the programming slot.
						s_nxt.slot10 = s_r.oe;
					end
					SEEBS_RDATA:
					begin
						if (s_r.mack)
						begin
							s_nxt.sh = s_r.rdata;
							s_nxt.oe = ~s_r.rdata[7];
							// Full counter width: wraps to zero after the last byte.
							s_nxt.addr = s_r.addr + 16'h1;
						end
						else
							s_nxt.st = SEEBS_IDLE;
					end
					default:
						s_nxt.st = SEEBS_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------

	// Link state register; the whole record clears on the resynchronised reset.
	always_ff @(posedge BUS_SAMPLE_CLK)
	begin
		if (lrst_r)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	// Array write port, fed only by the latch copy after a qualified stop.
	always_ff @(posedge BUS_SAMPLE_CLK)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// ------------------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------------------

	// The data output is a constant low; only the enable carries information.
	assign SDA_O = s_r.sda_o;
	assign SDA_OE = s_r.oe;

endmodule : seebs_top

/* logic/seebs_regs.svh */
// Constants of the serial EEPROM bus slave: address layout, page size, timing counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SEEBS_REGS_SVH
`define SEEBS_REGS_SVH

// ----------------------------------------------------------------------------
// Address layout
// ----------------------------------------------------------------------------
`define SEEBS_ADDR_BITS 16
`define SEEBS_ADDR_W_LARGE 15
`define SEEBS_ADDR_W_SMALL 14
`define SEEBS_PAGE_BITS 6
`define SEEBS_PAGE_BYTES 64
`define SEEBS_ERASED_BYTE 8'hFF
// Arbitrary seven-bit select identifier; the real part's code is not reused here.
`define SEEBS_DEV_ID_DEFAULT 7'h5B

// ----------------------------------------------------------------------------
// Bit slots and timing
// ----------------------------------------------------------------------------
`define SEEBS_LAST_DATA_BIT 4'h7
`define SEEBS_ACK_BIT 4'h8
// Marks the rest of the SCL high phase after a start, up to the fall before the first bit of a byte.
`define SEEBS_START_BIT 4'hF
`define SEEBS_CLK_FREQ_MHZ 20
`define SEEBS_PROG_TIME_US 10000
`define SEEBS_PROG_CYCLES (`SEEBS_PROG_TIME_US * `SEEBS_CLK_FREQ_MHZ)

`endif

/* logic/seebs_pkg.sv */
// Types of the serial EEPROM bus slave: engine states and the state records.
// Assumes the constants header sits beside it in the include path.
`include "seebs_regs.svh"

package seebs_pkg;

	// ------------------------------------------------------------------------
	// Engine states, Gray coded along select, address and data phases
	// ------------------------------------------------------------------------
	typedef enum logic [2:0] {
		SEEBS_IDLE = 3'h0,
		SEEBS_DEVSEL = 3'h1,
		SEEBS_ADDR_HI = 3'h3,
		SEEBS_ADDR_LO = 3'h2,
		SEEBS_WDATA = 3'h6,
		SEEBS_RDATA = 3'h7
	} seebs_state_t;

	// ------------------------------------------------------------------------
	// Link domain state record
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic scl_s1, scl_s2, scl_p;
		logic sda_s1, sda_s2, sda_p;
		logic wp_s1, wp_s2;
		logic done_s1, done_s2;
		seebs_state_t st;
		logic [3:0] bit_cnt;
		logic [7:0] sh;
		logic rw, oe, sda_o, wp_seen, mack, slot10;
		logic [`SEEBS_ADDR_BITS-1:0] addr;
		logic [`SEEBS_PAGE_BYTES-1:0][7:0] latch;
		logic [`SEEBS_PAGE_BYTES-1:0] valid;
		logic committing;
		logic [`SEEBS_PAGE_BITS-1:0] cidx;
		logic prog_t;
		logic [7:0] rdata;
	} seebs_link_t;

	// ------------------------------------------------------------------------
	// Program timer state record
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic req_s1, req_s2, req_p;
		logic done_t;
		logic [31:0] cnt;
	} seebs_tmr_t;

endpackage : seebs_pkg

/* logic/seebs_prog_timer.sv */
// Self-timed program cycle counter of the serial EEPROM bus slave, on the core clock.
// Assumes a start toggle from the link domain and hands back a done toggle.
`timescale 1ns/1ps
`include "seebs_regs.svh"

module seebs_prog_timer
	import seebs_pkg::*;
#(
	parameter int unsigned PROG_CYCLES = `SEEBS_PROG_CYCLES
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start_tgl,
	output logic done_tgl
);

	seebs_tmr_t s_r;
	seebs_tmr_t s_nxt;

	// Each start toggle is resynchronised, then arms one full write time.
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.req_s1 = start_tgl;
		s_nxt.req_s2 = s_r.req_s1;
		s_nxt.req_p = s_r.req_s2;
		if (s_r.cnt != 32'h0)
		begin
			s_nxt.cnt = s_r.cnt - 32'h1;
			if (s_r.cnt == 32'h1)
				s_nxt.done_t = ~s_r.done_t; // Done crosses back as a toggle.
		end
		else if (s_r.req_s2 != s_r.req_p)
			s_nxt.cnt = 32'(PROG_CYCLES); // A zero count would never finish.
	end

	// State register.
	always_ff @(posedge clk)
	begin
		if (rst)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign done_tgl = s_r.done_t;

endmodule : seebs_prog_timer

/* test/seebs_properties.sv */
// Pin checks of the serial EEPROM bus slave, taken on the bus sampling clock.
// Assumes a bind to the top module and an SDA wire resolved with a pull-up outside.
`timescale 1ns/1ps

module seebs_properties (
	input wire logic CLK,
	input wire logic RST,
	input wire logic BUS_SAMPLE_CLK,
	input wire logic SCL,
	input wire logic SDA_I,
	input wire logic SDA_O,
	input wire logic SDA_OE,
	input wire logic WRITE_PROTECT_INPUT
);
	logic scl_q_r, sda_q_r, first_r, rw_r;
	logic [3:0] cnt_r;
	logic [1:0] hold_r;
	logic start_ev, stop_ev, rise_ev;

	// Bus events from raw pins; the slave sees them a few edges later.
	assign start_ev = SCL && scl_q_r && !SDA_I && sda_q_r;
	assign stop_ev = SCL && scl_q_r && SDA_I && !sda_q_r;
	assign rise_ev = SCL && !scl_q_r;

	// Bit slot count per byte, first byte flag and direction of the command.
	always_ff @(posedge BUS_SAMPLE_CLK)
	begin
		scl_q_r <= SCL;
		sda_q_r <= SDA_I;
		// The slave clears its pins only after its own resynchronised reset.
		if (RST)
			hold_r <= 2'h3;
		else if (hold_r != 2'h0)
			hold_r <= hold_r - 2'h1;
		if (RST || start_ev || stop_ev)
		begin
			cnt_r <= 4'h0;
			first_r <= 1'b1;
			rw_r <= 1'b0;
		end
		else if (rise_ev)
		begin
			cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
			if (first_r && cnt_r == 4'h7)
				rw_r <= SDA_I;
			if (cnt_r == 4'h9)
				first_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge BUS_SAMPLE_CLK); endclocking
	default disable iff (RST || hold_r != 2'h0);

	sequence s_quiet;
		!SDA_OE [*8];
	endsequence
	sequence s_low_two;
		!SCL ##1 !SCL;
	endsequence

	a_oe_high_steady: assert property (SCL && scl_q_r |-> $stable(SDA_OE))
		else $error("SDA drive moved while SCL high");
	a_sda_o_low: assert property (SDA_O == 1'b0)
		else $error("SDA output level not low");
	a_start_quiet: assert property (start_ev |-> s_quiet)
		else $error("SDA driven right after start");
	a_stop_quiet: assert property (stop_ev |-> s_quiet)
		else $error("SDA driven right after stop");
	a_write_no_drive: assert property (SCL && scl_q_r && (first_r || !rw_r) && cnt_r != 4'h9
		|-> !SDA_OE)
		else $error("SDA driven outside an ack slot");
	a_read_release: assert property (SCL && scl_q_r && rw_r && !first_r && cnt_r == 4'h9
		|-> !SDA_OE)
		else $error("SDA driven in master ack slot");
	a_nack_standby: assert property (SCL && scl_q_r && rw_r && !first_r && cnt_r == 4'h9
		&& SDA_I |-> s_quiet)
		else $error("output went on after no ack");
	a_drive_in_low: assert property ($rose(SDA_OE) |-> s_low_two)
		else $error("SDA drive began outside SCL low");
endmodule : seebs_properties

bind seebs_top seebs_properties chk (
	.CLK(CLK),
	.RST(RST),
	.BUS_SAMPLE_CLK(BUS_SAMPLE_CLK),
	.SCL(SCL),
	.SDA_I(SDA_I),
	.SDA_O(SDA_O),
	.SDA_OE(SDA_OE),
	.WRITE_PROTECT_INPUT(WRITE_PROTECT_INPUT)
);

/* test/seebs_master_model.sv */
// Two-wire bus master model: drives SCL and pulls SDA low on request.
// Assumes SDA is resolved with a pull-up outside and fed back on sda.
`timescale 1ns/1ps

module seebs_master_model (
	input wire logic lclk,
	input wire logic sda,
	output logic scl,
	output logic drv_low
);
	// Idle bus: clock stands high and SDA is released to the pull-up.
	initial
	begin
		scl = 1'b1;
		drv_low = 1'b0;
	end

	// Each phase spans six link edges, above the four the slave needs.
	task automatic tick(input int n);
		repeat (n) @(posedge lclk);
	endtask : tick

	task automatic slot(input logic b, output logic r);
		tick(3);
		drv_low <= ~b;
		tick(3);
		scl <= 1'b1;
		tick(3);
		r = sda;
		tick(3);
		scl <= 1'b0;
	endtask : slot

	// Start when is_stop is low, stop otherwise; SDA is set up with SCL low, then flips with SCL high.
	task automatic cond(input logic is_stop);
		tick(3);
		drv_low <= is_stop;
		tick(3);
		scl <= 1'b1;
		tick(3);
		drv_low <= ~is_stop;
		tick(3);
		scl <= is_stop;
	endtask : cond

	// Bytes go out MSB first; the ninth slot is left to the slave.
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			slot(d[i], r);
		slot(1'b1, r);
		ack = ~r;
	endtask : wbyte

	task automatic rbyte(input logic give, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			slot(1'b1, r);
			d[i] = r;
		end
		slot(~give, r);
	endtask : rbyte
endmodule : seebs_master_model

/* test/tb_top.sv */
// Self-checking bench of the serial EEPROM bus slave behind a master model.
// Assumes the package, constants header and master model compile first.
`timescale 1ns/1ps
`include "seebs_regs.svh"

module tb_top;
	// Arbitrary select identifier, the design's default one as well.
	localparam logic [6:0] ID = `SEEBS_DEV_ID_DEFAULT;
	logic clk;
	logic lclk;
	logic rst;
	logic wp;
	logic scl, drv_low, sda_o, sda_oe;
	wire sda;
	int fails = 0;
	int cmp_count = 0;
	logic [7:0] mem [int];

	// Core clock 50 ns; link clock 125 ns with an unrelated phase.
	always #25 clk = ~clk;
	initial
	begin
		clk = 1'b0;
		lclk = 1'b0;
		#17;
		forever #62.5 lclk = ~lclk;
	end
	// Open-drain wire with a pull-up: low when either party pulls.
	assign sda = (sda_oe ? sda_o : 1'b1) & ~drv_low;

	seebs_top #(.PROG_CYCLES(500)) DUT (
		.CLK(clk),
		.RST(rst),
		.BUS_SAMPLE_CLK(lclk),
		.SCL(scl),
		.SDA_I(sda),
		.SDA_O(sda_o),
		.SDA_OE(sda_oe),
		.WRITE_PROTECT_INPUT(wp)
	);
	seebs_master_model m (
		.lclk(lclk),
		.sda(sda),
		.scl(scl),
		.drv_low(drv_low)
	);

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Unwritten locations hold the erased value.
	function automatic logic [7:0] exp_at(input int a);
		return mem.exists(a) ? mem[a] : `SEEBS_ERASED_BYTE;
	endfunction : exp_at

	task automatic sel(input logic rw, input logic exp_ack);
		logic ack;
		m.cond(1'b0);
		m.wbyte({ID, rw}, ack);
		check("select ack", 8'(ack), 8'(exp_ack));
	endtask : sel

	task automatic set_addr(input logic [15:0] a);
		logic ack;
		sel(1'b0, 1'b1);
		m.wbyte(a[15:8], ack);
		check("addr hi ack", 8'(ack), 8'h01);
		m.wbyte(a[7:0], ack);
		check("addr lo ack", 8'(ack), 8'h01);
	endtask : set_addr

	// The model keeps the row fixed and wraps the low six bits.
	task automatic write(input logic [15:0] a, input int n, input logic [7:0] d0, input logic ok);
		logic ack;
		set_addr(a);
		for (int k = 0; k < n; k++)
		begin
			m.wbyte(d0 + 8'(k), ack);
			check("data ack", 8'(ack), 8'(ok));
			if (ok)
				mem[{a[14:6], 6'(a[5:0] + k)}] = d0 + 8'(k);
		end
		m.cond(1'b1);
	endtask : write

	task automatic read(input int a, input int n);
		logic [7:0] d;
		for (int k = 0; k < n; k++)
		begin
			m.rbyte(k < n - 1, d);
			check("read data", d, exp_at((a + k) % (1 << 15)));
		end
		m.cond(1'b1);
	endtask : read

	task automatic poll();
		logic ack;
		ack = 1'b0;
		for (int p = 0; p < 12 && ack !== 1'b1; p++)
		begin
			m.cond(1'b0);
			m.wbyte({ID, 1'b0}, ack);
			m.cond(1'b1);
			if (p == 0)
				check("busy nack", 8'(ack), 8'h00);
		end
		check("ready ack", 8'(ack), 8'h01);
	endtask : poll

	task automatic sc_select();
		logic ack;
		m.cond(1'b0);
		m.wbyte({ID ^ 7'h01, 1'b0}, ack);
		check("foreign select", 8'(ack), 8'h00);
		m.wbyte(8'h00, ack);
		check("standby byte", 8'(ack), 8'h00);
		m.cond(1'b1);
		set_addr(16'h0123);
		sel(1'b1, 1'b1);
		read(16'h0123, 2);
	endtask : sc_select

	// 66 bytes into one row: the first two are overwritten, b15 is ignored.
	task automatic sc_page();
		write(16'h803E, 66, 8'h10, 1'b1);
		poll();
		set_addr(16'h003C);
		sel(1'b1, 1'b1);
		read(16'h003C, 6);
	endtask : sc_page

	// Protected data and a write cut by a repeated start must not program.
	task automatic sc_noprog();
		logic ack;
		@(posedge clk) wp <= 1'b1;
		write(16'h0240, 1, 8'h77, 1'b0);
		sel(1'b1, 1'b1);
		read(16'h0240, 1);
		@(posedge clk) wp <= 1'b0;
		set_addr(16'h0280);
		m.wbyte(8'h55, ack);
		check("data ack", 8'(ack), 8'h01);
		set_addr(16'h0280);
		sel(1'b1, 1'b1);
		read(16'h0280, 1);
	endtask : sc_noprog

	// Top address wraps to zero; then a current read continues from there.
	task automatic sc_wrap();
		write(16'h7FFF, 1, 8'hA5, 1'b1);
		poll();
		set_addr(16'h7FFF);
		sel(1'b1, 1'b1);
		read(16'h7FFF, 2);
		sel(1'b1, 1'b1);
		read(16'h0001, 1);
	endtask : sc_wrap

	task automatic complete_run();
		if (fails == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	// Reset spans three core clocks, which still covers one link edge.
	initial
	begin
		rst = 1'b1;
		wp = 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge lclk);
		sc_select();
		sc_page();
		sc_noprog();
		sc_wrap();
		complete_run();
	end

	// The whole sequence needs about 2 ms; twice that means a hang.
	initial
	begin
		#4000000;
		fails++;
		complete_run();
	end
endmodule : tb_top
